// File: core/dual_counter_pkg.sv
// Constants, register map and types for the dual 16-bit timer/event counter.
// Assumes a single 200 MHz clock and an AXI4-Lite slave front end.
// Functional notes
// - Two 16-bit up-counters, clock divided by four
// - Low-byte write fills holding buffer only
// - High-byte write loads byte plus buffer into preload
// - High-byte read latches live low byte
// - High-byte read blocks counter clock briefly
// - Count to FFFF, then reload from preload
// - Overflow sets request flag, one cycle after reload
// - Run bit 4 enables counting
// - Run bit cleared by software or at pulse-width end
// - Pulse-width mode clears run bit when done
// - Pulse-width: start on edge, stop on return
// - Pulse-width overflow reloads and flags too
// - Control bit 3 selects active edge
// - Mode field bits 7:6 encoding
// - Event mode counts pin edges, timer instruction clock
// - Overflow is a wake-up source
// - Cleared irq enable suppresses interrupt service
// - Stopped: preload write also loads counter
// - Running: preload write waits for reload
// - Control bits 0-2 and 5 read zero
// - Counter 1 at 0F, 10, 11 behaves same
package dual_counter_pkg;

	// --------------------------------------------------------------
	// Register map (printed offsets are indices; byte address is 4x)
	// --------------------------------------------------------------
	localparam logic [7:0] IDX_C0_HIGH   = 8'h0C;
	localparam logic [7:0] IDX_C0_LOW    = 8'h0D;
	localparam logic [7:0] IDX_C0_CTRL   = 8'h0E;
	localparam logic [7:0] IDX_C1_HIGH   = 8'h0F;
	localparam logic [7:0] IDX_C1_LOW    = 8'h10;
	localparam logic [7:0] IDX_C1_CTRL   = 8'h11;
	localparam logic [7:0] IDX_INTERRUPT_CONTROL_REGISTER      = 8'h0B;
	localparam logic [7:0] IDX_STEP      = 8'h03;

	// --------------------------------------------------------------
	// Field positions and values
	// --------------------------------------------------------------
	localparam int         BIT_EDGE      = 3;
	localparam int         BIT_RUN       = 4;
	localparam int         BIT_MODE_LO   = 6;
	localparam logic [7:0] CTRL_MASK     = 8'hD8;
	localparam logic [7:0] CTRL_RESET    = 8'h08;
	localparam int         BIT_IEN0      = 2;
	localparam int         BIT_IEN1      = 3;
	localparam int         BIT_FLAG0     = 5;
	localparam int         BIT_FLAG1     = 6;
	localparam logic [1:0] MODE_EVENT    = 2'h1;
	localparam logic [1:0] MODE_TIMER    = 2'h2;
	localparam logic [1:0] MODE_PULSE    = 2'h3;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int         CLK_DIV       = 4;
	localparam logic [1:0] DIV_LAST      = 2'(CLK_DIV - 1);

	typedef enum logic [1:0] {PW_IDLE, PW_ARMED, PW_MEASURE, PW_DONE} pw_state_t;

endpackage : dual_counter_pkg

// File: core/counter_ctl_if.sv
// Carrier between the register front end and one counter channel.
// Assumes both ends sit in the aclk domain.
`timescale 1ns/100ps
interface counter_ctl_if;
	logic [7:0]  wr_data;
	logic        wr_low;
	logic        wr_high;
	logic        wr_ctrl;
	logic        rd_high;
	logic [7:0]  control;
	logic [7:0]  read_high;
	logic [7:0]  read_low;
	logic        overflow;

	modport front (output wr_data, wr_low, wr_high, wr_ctrl, rd_high,
		input control, read_high, read_low, overflow);
	modport chan  (input wr_data, wr_low, wr_high, wr_ctrl, rd_high,
		output control, read_high, read_low, overflow);
endinterface : counter_ctl_if

// File: core/counter_channel.sv
// One 16-bit timer/event counter with preload, holding buffer and control.
// Assumes tick is a one-cycle enable every fourth aclk; ext_in synchronous.
`timescale 1ns/100ps
module counter_channel
	import dual_counter_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic tick,
	input  wire logic ext_in,
	counter_ctl_if.chan ctl
);

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] preload;
		logic [7:0]  hold_low;
		logic [7:0]  control;
		logic        ext_prev;
		logic        blocked;
		logic        ovf;
		pw_state_t   pw;
	} chan_state_t;

	chan_state_t st;
	chan_state_t next_st;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0]  mode;
		logic        run;
		logic        active_edge;
		logic        back_edge;
		logic        step;
		logic        rise;
		logic        fall;
		mode        = st.control[7:6];
		run         = st.control[BIT_RUN];
		rise        = ext_in & ~st.ext_prev;
		fall        = ~ext_in & st.ext_prev;
		active_edge = st.control[BIT_EDGE] ? fall : rise;
		back_edge   = st.control[BIT_EDGE] ? rise : fall;
		next_st     = st;
		next_st.ext_prev = ext_in;
		next_st.ovf      = 1'b0;
		next_st.blocked  = ctl.rd_high;
		step = 1'b0;
		// Pulse-width sequencer
		if (mode == MODE_PULSE && run) begin
			case (st.pw)
				PW_IDLE, PW_DONE: next_st.pw = PW_ARMED;
				PW_ARMED: if (active_edge) next_st.pw = PW_MEASURE;
				PW_MEASURE: begin
					if (back_edge) begin
						next_st.pw = PW_DONE;
						next_st.control[BIT_RUN] = 1'b0;
					end
				end
				default: next_st.pw = PW_IDLE;
			endcase
		end
		// Counting source by mode
		if (run && !ctl.rd_high && !st.blocked) begin
			case (mode)
				MODE_TIMER: step = tick;
				MODE_EVENT: step = active_edge;
				MODE_PULSE: step = tick && st.pw == PW_MEASURE;
				default:    step = 1'b0;
			endcase
		end
		if (step) begin
			if (st.count == 16'hFFFF) begin
				next_st.count = st.preload;
				next_st.ovf   = 1'b1;
			end else begin
				next_st.count = st.count + 16'h0001;
			end
		end
		// Register accesses
		if (ctl.rd_high) next_st.hold_low = st.count[7:0];
		if (ctl.wr_low) next_st.hold_low = ctl.wr_data;
		if (ctl.wr_high) begin
			next_st.preload = {ctl.wr_data, st.hold_low};
			if (!run) next_st.count = {ctl.wr_data, st.hold_low};
		end
		if (ctl.wr_ctrl) begin
			next_st.control = ctl.wr_data & CTRL_MASK;
			if (ctl.wr_data[BIT_RUN]) next_st.pw = PW_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st         <= '0;
			st.control <= CTRL_RESET;
			st.pw      <= PW_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign ctl.control   = st.control;
	assign ctl.read_high = st.count[15:8];
	assign ctl.read_low  = st.hold_low;
	assign ctl.overflow  = st.ovf;

endmodule : counter_channel

// File: core/dual_timer_event_counter.sv
// Top of the dual timer/event counter: AXI4-Lite slave, divider, flags.
// Assumes aclk at 200 MHz, synchronous active-low reset, synchronous pins.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/100ps
module dual_timer_event_counter
	import dual_counter_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [1:0]  external_count_input,
	output logic             wake_request,
	output logic             counter0_service,
	output logic             counter1_service
);

	typedef struct packed {
		logic [1:0]  div;
		logic        tick;
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [7:0]  w_data;
		logic        w_lane0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  interrupt_control_register;
		logic        wake;
		logic [1:0]  service;
	} top_state_t;

	top_state_t st;
	top_state_t next_st;

	counter_ctl_if ch0 ();
	counter_ctl_if ch1 ();

	// Register index from a byte address; unaligned gives no match
	function automatic logic [7:0] reg_index(input logic [7:0] addr);
		reg_index = (addr[1:0] == 2'h0) ? {2'h0, addr[7:2]} : 8'hFF;
	endfunction : reg_index

	// ----------------------------------------------------------------
	// Counter channels (second at the next three indices)
	// ----------------------------------------------------------------
	counter_channel u_ch0 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (st.tick),
		.ext_in  (external_count_input[0]),
		.ctl     (ch0.chan)
	);
	counter_channel u_ch1 (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (st.tick),
		.ext_in  (external_count_input[1]),
		.ctl     (ch1.chan)
	);

	// ----------------------------------------------------------------
	// Bus decode and next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       do_wr;
		logic       do_rd;
		logic [7:0] widx;
		logic [7:0] ridx;
		logic [7:0] rbyte;
		logic       rhit;
		logic       whit;
		rbyte   = 8'h00;
		next_st = st;
		// Instruction-clock enable, one pulse in four
		next_st.div  = (st.div == DIV_LAST) ? 2'h0 : st.div + 2'h1;
		next_st.tick = (st.div == DIV_LAST);
		if (s_axi_awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_held) begin
			next_st.w_held  = 1'b1;
			next_st.w_data  = s_axi_wdata[7:0];
			next_st.w_lane0 = s_axi_wstrb[0];
		end
		do_wr = st.aw_held && st.w_held && !st.bvalid;
		do_rd = s_axi_arvalid && !st.rvalid;
		widx  = reg_index(st.aw_addr);
		ridx  = reg_index(s_axi_araddr);
		whit  = widx == IDX_INTERRUPT_CONTROL_REGISTER ||
			(widx >= IDX_C0_HIGH && widx <= IDX_C1_CTRL);
		ch0.wr_data = st.w_data;
		ch1.wr_data = st.w_data;
		ch0.wr_low  = do_wr && st.w_lane0 && widx == IDX_C0_LOW;
		ch0.wr_high = do_wr && st.w_lane0 && widx == IDX_C0_HIGH;
		ch0.wr_ctrl = do_wr && st.w_lane0 && widx == IDX_C0_CTRL;
		ch1.wr_low  = do_wr && st.w_lane0 && widx == IDX_C1_LOW;
		ch1.wr_high = do_wr && st.w_lane0 && widx == IDX_C1_HIGH;
		ch1.wr_ctrl = do_wr && st.w_lane0 && widx == IDX_C1_CTRL;
		ch0.rd_high = do_rd && ridx == IDX_C0_HIGH;
		ch1.rd_high = do_rd && ridx == IDX_C1_HIGH;
		if (do_wr) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = whit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
		// Read mux
		rhit = 1'b1;
		if (ridx == IDX_C0_HIGH) begin
			rbyte = ch0.read_high;
		end else if (ridx == IDX_C0_LOW) begin
			rbyte = ch0.read_low;
		end else if (ridx == IDX_C0_CTRL) begin
			rbyte = ch0.control;
		end else if (ridx == IDX_C1_HIGH) begin
			rbyte = ch1.read_high;
		end else if (ridx == IDX_C1_LOW) begin
			rbyte = ch1.read_low;
		end else if (ridx == IDX_C1_CTRL) begin
			rbyte = ch1.control;
		end else if (ridx == IDX_INTERRUPT_CONTROL_REGISTER) begin
			rbyte = st.interrupt_control_register;
		end else begin
			rbyte = 8'h00;
			rhit  = 1'b0;
		end
		if (do_rd) begin
			next_st.rvalid = 1'b1;
			next_st.rdata  = {24'h000000, rbyte};
			next_st.rresp  = rhit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st.rvalid && s_axi_rready) next_st.rvalid = 1'b0;
		// Interrupt control register: software write, then hardware set wins
		if (do_wr && st.w_lane0 && widx == IDX_INTERRUPT_CONTROL_REGISTER) next_st.interrupt_control_register = st.w_data & 8'h6C;
		if (ch0.overflow) next_st.interrupt_control_register[BIT_FLAG0] = 1'b1;
		if (ch1.overflow) next_st.interrupt_control_register[BIT_FLAG1] = 1'b1;
		next_st.wake = ch0.overflow | ch1.overflow;
		next_st.service[0] = next_st.interrupt_control_register[BIT_FLAG0] & next_st.interrupt_control_register[BIT_IEN0];
		next_st.service[1] = next_st.interrupt_control_register[BIT_FLAG1] & next_st.interrupt_control_register[BIT_IEN1];
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready    = ~st.aw_held;
	assign s_axi_wready     = ~st.w_held;
	assign s_axi_bvalid     = st.bvalid;
	assign s_axi_bresp      = st.bresp;
	assign s_axi_arready    = ~st.rvalid;
	assign s_axi_rvalid     = st.rvalid;
	assign s_axi_rdata      = st.rdata;
	assign s_axi_rresp      = st.rresp;
	assign wake_request     = st.wake;
	assign counter0_service = st.service[0];
	assign counter1_service = st.service[1];

endmodule : dual_timer_event_counter

// File: dv/dual_counter_asserts.sv
// Checker for the dual counter top: bus handshakes and wake pulses.
// Assumes it is bound to dual_timer_event_counter and sees only its ports.
`timescale 1ns/100ps
module dual_counter_asserts
	import dual_counter_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        wake_request
);
	// One clock domain, reset disables all
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Ticks come every fourth clock, so overflows outside event mode cannot be closer
	sequence s_quiet; !wake_request [*3]; endsequence
	property p_wake_gap; wake_request |=> s_quiet; endproperty
	property p_ar_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_ar_stop; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_r_err; s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	property p_aw_take; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	property p_w_take; s_axi_wvalid && s_axi_wready |=> !s_axi_wready; endproperty
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	// Both halves taken together: answer one cycle after the acting edge
	sequence s_b_late; !s_axi_bvalid ##1 s_axi_bvalid; endsequence
	property p_b_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
		!s_axi_bvalid |=> s_b_late; endproperty
	a_wake_gap: assert property (p_wake_gap)
		else $error("wake pulses too close");
	a_ar_ans: assert property (p_ar_ans)
		else $error("read answer late");
	a_ar_stop: assert property (p_ar_stop)
		else $error("arready during read answer");
	a_r_hold: assert property (p_r_hold)
		else $error("read answer dropped");
	a_r_err: assert property (p_r_err)
		else $error("error read with data");
	a_r_upper: assert property (p_r_upper)
		else $error("upper read bits set");
	a_aw_take: assert property (p_aw_take)
		else $error("awready stayed high");
	a_w_take: assert property (p_w_take)
		else $error("wready stayed high");
	a_b_hold: assert property (p_b_hold)
		else $error("write answer dropped");
	a_b_ans: assert property (p_b_ans)
		else $error("write answer not on time");
endmodule : dual_counter_asserts

bind dual_timer_event_counter dual_counter_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .wake_request(wake_request));

// File: dv/dual_timer_event_counter_tb.sv
// Self-checking bench for the dual timer/event counter.
// Assumes a 200 MHz clock and an AXI4-Lite master built from tasks.
`timescale 1ns/100ps
module dual_timer_event_counter_tb
	import dual_counter_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, got;
	logic [31:0] wdata;
	logic [1:0]  ext, resp;
	wire         awready, wready, bvalid, arready, rvalid, wake, svc0, svc1;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          fails, n_compared;

	dual_timer_event_counter dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .external_count_input(ext), .wake_request(wake),
		.counter0_service(svc0), .counter1_service(svc1));

	// 5 ns clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize

	task automatic timeout();
		fails++;
		$display("MISMATCH wait expected answer seen none");
		summarize();
	endtask : timeout

	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", w, e, s);
		end
	endtask : chk

	// Bus write: both channels offered, held until taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		int n;
		awaddr <= {idx[5:0], 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		bready <= 1'b0;
		@(posedge aclk);
		if (n == 64) timeout();
	endtask : wr

	// Bus read: data and response taken at the answer edge
	task automatic rd(input logic [7:0] idx);
		int n;
		araddr <= {idx[5:0], 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		got = rdata[7:0];
		resp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
		if (n == 64) timeout();
	endtask : rd

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e, input string w);
		rd(idx);
		chk(w, e, got);
	endtask : rdchk

	task automatic t_reset();
		rdchk(IDX_C0_CTRL, CTRL_RESET, "ctrl0");
		rdchk(IDX_C1_CTRL, CTRL_RESET, "ctrl1");
		rdchk(IDX_INTERRUPT_CONTROL_REGISTER, 8'h00, "interrupt_control_register");
		rd(8'h20);
		chk("unmapped resp", {6'h0, RESP_SLVERR}, {6'h0, resp});
		chk("unmapped data", 8'h00, got);
		wr(8'h20, 8'h00);
		chk("unmapped wresp", {6'h0, RESP_SLVERR}, {6'h0, resp});
		wr(IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
		chk("mapped wresp", {6'h0, RESP_OKAY}, {6'h0, resp});
		$display("test reset done");
	endtask : t_reset

	// Byte buffer, stopped preload, unused control bits
	task automatic t_buffer(input logic [7:0] b);
		wr(b + 8'h1, 8'h34);
		rdchk(b, 8'h00, "high after low write");
		rdchk(b + 8'h1, 8'h00, "low from latch");
		wr(b + 8'h1, 8'h34);
		wr(b, 8'h12);
		repeat (40) @(posedge aclk);
		rdchk(b, 8'h12, "high stopped");
		rdchk(b + 8'h1, 8'h34, "low stopped");
		wr(b + 8'h2, 8'hFF);
		rdchk(b + 8'h2, CTRL_MASK, "ctrl bits");
		wr(b + 8'h2, 8'h08);
		$display("test buffer done");
	endtask : t_buffer

	// Timer overflow, reload, flag, service gating
	task automatic t_overflow(input logic [7:0] b, input logic [7:0] en, input logic [7:0] fl);
		int n;
		wr(b + 8'h1, 8'hF0);
		wr(b, 8'hFF);
		wr(IDX_INTERRUPT_CONTROL_REGISTER, en);
		wr(b + 8'h2, 8'h90);
		wr(b + 8'h1, 8'h00);
		wr(b, 8'h80);
		rdchk(b, 8'hFF, "high running");
		for (n = 0; n < 400 && wake !== 1'b1; n++) @(posedge aclk);
		if (n == 400) timeout();
		rdchk(IDX_INTERRUPT_CONTROL_REGISTER, en | fl, "flag");
		chk("service on", 8'h1, {7'h0, fl[5] ? svc0 : svc1});
		rdchk(b, 8'h80, "high reloaded");
		rdchk(b + 8'h2, 8'h90, "run kept");
		wr(IDX_INTERRUPT_CONTROL_REGISTER, fl);
		chk("service off", 8'h0, {7'h0, fl[5] ? svc0 : svc1});
		wr(b + 8'h2, 8'h80);
		wr(IDX_INTERRUPT_CONTROL_REGISTER, 8'h00);
		$display("test overflow done");
	endtask : t_overflow

	task automatic pin(input int p, input logic v, input int c);
		ext[p] <= v;
		repeat (c) @(posedge aclk);
	endtask : pin

	// Event count on both edge selections
	task automatic t_event(input logic [7:0] b, input int p);
		wr(b + 8'h1, 8'hFE);
		wr(b, 8'h00);
		wr(b + 8'h2, 8'h50);
		repeat (3) begin
			pin(p, 1'b1, 8);
			pin(p, 1'b0, 8);
		end
		rdchk(b, 8'h01, "event high");
		rdchk(b + 8'h1, 8'h01, "event low");
		wr(b + 8'h2, 8'h58);
		pin(p, 1'b1, 8);
		pin(p, 1'b0, 8);
		rdchk(b, 8'h01, "falling high");
		rdchk(b + 8'h1, 8'h02, "falling low");
		wr(b + 8'h2, 8'h08);
		$display("test event done");
	endtask : t_event

	// One pulse measured, run cleared, later pulse ignored
	task automatic t_pulse(input logic [7:0] b, input int p);
		logic [7:0] v;
		wr(b + 8'h1, 8'h00);
		wr(b, 8'h00);
		wr(b + 8'h2, 8'hD0);
		pin(p, 1'b1, 40);
		pin(p, 1'b0, 8);
		rdchk(b + 8'h2, 8'hC0, "run cleared");
		rdchk(b, 8'h00, "width high");
		rd(b + 8'h1);
		v = got;
		chk("width near ten", 8'h1, {7'h0, got >= 8'd9 && got <= 8'd11});
		pin(p, 1'b1, 40);
		pin(p, 1'b0, 8);
		rd(b);
		rdchk(b + 8'h1, v, "width held");
		$display("test pulse done");
	endtask : t_pulse

	// Reset, then the scenarios for both counters
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, ext} = 50'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_buffer(IDX_C0_HIGH);
		t_buffer(IDX_C1_HIGH);
		t_overflow(IDX_C0_HIGH, 8'h04, 8'h20);
		t_overflow(IDX_C1_HIGH, 8'h08, 8'h40);
		t_event(IDX_C0_HIGH, 0);
		t_event(IDX_C1_HIGH, 1);
		t_pulse(IDX_C0_HIGH, 0);
		t_pulse(IDX_C1_HIGH, 1);
		summarize();
	end
endmodule : dual_timer_event_counter_tb
